// >>> rtl/plc_cluster_io.sv
// Top of the logic fabric: routing pool, clusters, clock network and configuration port.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module plc_cluster_io
  import plc_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  input  wire logic               clk_en,
  input  wire plc_reg_req_t       reg_req,
  output logic [DATA_W-1:0]       reg_rdata,
  input  wire logic [NUM_DED-1:0] ded_in,
  input  wire logic               dedicated_clock_pin_0,
  input  wire logic               dedicated_clock_pin_1,
  input  wire logic               dedicated_clock_pin_2,
  input  wire logic               dedicated_clock_pin_3,
  input  wire logic [NUM_IO-1:0]  io_pin_i,
  output logic      [NUM_IO-1:0]  io_pin_o,
  output logic      [NUM_IO-1:0]  io_pin_oe_b
);

  typedef struct packed {
    plc_io_cfg_t  [NUM_IO-1:0]                            io_cfg;
    plc_oe_cfg_t  [NUM_CLUSTERS-1:0]                      oe_cfg;
    plc_blk_ctl_t [NUM_BLK-1:0]                           blk_ctl;
    logic         [NUM_BLK-1:0][BLK_OUT-1:0][1:0][BLK_IN-1:0] term;
    logic         [NUM_BLK-1:0][BLK_IN-1:0][7:0]          in_sel;
    logic         [NUM_CLINES-1:0][2:0]                   clk_src;
    logic         [NUM_CLINES-1:0]                        line_prev;
    logic         [GRP_W-1:0]                             global_routing_pool;
    logic         [DATA_W-1:0]                            rdata;
  } plc_top_state_t;

  plc_top_state_t           st_q;
  plc_top_state_t           st_d;

  logic [NUM_CLK_PIN-1:0]   clk_pins;
  logic [BLK_OUT_ALL-1:0]   blk_out;
  logic [NUM_IO-1:0]        io_in;
  logic [NUM_CLUSTERS-1:0]  cl_oe;
  logic [NUM_CLINES-1:0]    line_lvl;
  logic [NUM_CLINES-1:0]    line_rise;
  logic                     gen_clk;
  logic                     pin_cell_clock_line_0;
  logic                     pin_cell_clock_line_1;
  logic [ADDR_W-1:0]        term_off;
  logic [ADDR_W-1:0]        sel_off;
  logic [ADDR_W-1:0]        grp_off;
  logic [GRP_PAD_W-1:0]     grp_pad;

  assign clk_pins = {dedicated_clock_pin_3, dedicated_clock_pin_2,
                     dedicated_clock_pin_1, dedicated_clock_pin_0};
  assign term_off = reg_req.addr - TERM_BASE;
  assign sel_off  = reg_req.addr - IN_SEL_BASE;
  assign grp_off  = reg_req.addr - GRP_RD_BASE;
  assign grp_pad  = {{(GRP_PAD_W - GRP_W){1'b0}}, st_q.global_routing_pool};

  // Picks one pool or dedicated input signal for a logic block input.
  function automatic logic grp_pick(input logic [7:0]         sel,
                                    input logic [GRP_W-1:0]   pool,
                                    input logic [NUM_DED-1:0] ded);
    logic [7:0] ded_idx;
    ded_idx = sel - SEL_GRP_END;
    if (sel < SEL_GRP_END)
    begin
      return pool[sel];
    end
    else if (sel < SEL_DED_END)
    begin
      return ded[ded_idx[2:0]];
    end
    return 1'b0;
  endfunction

  // Maps a clock line source code to a pin or the generated clock.
  function automatic logic clk_pick(input logic [2:0]             src,
                                    input logic [NUM_CLK_PIN-1:0] pins,
                                    input logic                   gen);
    if (src == CSRC_GEN)
    begin
      return gen;
    end
    else if (src < CSRC_GEN)
    begin
      return pins[src[1:0]];
    end
    return 1'b0;
  endfunction

  assign gen_clk = blk_out[CLKGEN_BLK * BLK_OUT];

  for (genvar k = 0; k < NUM_CLINES; k++) begin : g_cline
    assign line_lvl[k]  = clk_pick(st_q.clk_src[k], clk_pins, gen_clk);
    assign line_rise[k] = line_lvl[k] & ~st_q.line_prev[k];
  end

  assign pin_cell_clock_line_0 = line_lvl[NUM_LCLK];
  assign pin_cell_clock_line_1 = line_lvl[NUM_LCLK + 1];

  // three identical clusters of eight blocks
  for (genvar b = 0; b < NUM_BLK; b++) begin : g_blk
    logic [BLK_IN-1:0] blk_in;
    plc_blk_cfg_t      blk_cfg;

    // inputs from pool and dedicated pins
    for (genvar i = 0; i < BLK_IN; i++) begin : g_in
      assign blk_in[i] = grp_pick(st_q.in_sel[b][i], st_q.global_routing_pool, ded_in);
    end

    for (genvar j = 0; j < BLK_OUT; j++) begin : g_trm
      assign blk_cfg.mask[j] = st_q.term[b][j][0];
      assign blk_cfg.inv[j]  = st_q.term[b][j][1];
    end
    assign blk_cfg.ctl = st_q.blk_ctl[b];

    plc_logic_block_unit u_lbu (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .clk_en    (clk_en),
      .cfg       (blk_cfg),
      .blk_in    (blk_in),
      .lclk_rise (line_rise[NUM_LCLK-1:0]),
      .blk_out   (blk_out[b*BLK_OUT +: BLK_OUT])
    );
  end

  for (genvar c = 0; c < NUM_CLUSTERS; c++) begin : g_oe
    logic [CL_OUTS-1:0] cl_outs;
    assign cl_outs  = blk_out[c*CL_OUTS +: CL_OUTS];
    assign cl_oe[c] = st_q.oe_cfg[c].force_on
                    | (cl_outs[st_q.oe_cfg[c].src] ^ st_q.oe_cfg[c].invert);
  end

  for (genvar p = 0; p < NUM_IO; p++) begin : g_io
    localparam int CL = p / IO_PER_CL;
    logic [CL_OUTS-1:0] cl_outs;
    logic               ioclk_lvl;
    logic               ioclk_rise;

    assign cl_outs    = blk_out[CL*CL_OUTS +: CL_OUTS];
    assign ioclk_lvl  = st_q.io_cfg[p].clk_sel ? pin_cell_clock_line_1 : pin_cell_clock_line_0;
    assign ioclk_rise = line_rise[NUM_LCLK + int'(st_q.io_cfg[p].clk_sel)];

    plc_io_cell u_ioc (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .clk_en    (clk_en),
      .cfg       (st_q.io_cfg[p]),
      .out_data  (cl_outs[st_q.io_cfg[p].src]),
      .cl_oe     (cl_oe[CL]),
      .line_lvl  (ioclk_lvl),
      .line_rise (ioclk_rise),
      .pin_i     (io_pin_i[p]),
      .pin_o     (io_pin_o[p]),
      .pin_oe_b  (io_pin_oe_b[p]),
      .in_val    (io_in[p])
    );
  end

  always_comb
  begin
    st_d = st_q;
    st_d.line_prev = line_lvl;
    // The pool is sampled once per cycle, which breaks any combinatorial
    // feedback loop through the fabric at the price of one cycle of latency.
    // block outputs fed back
    st_d.global_routing_pool[BLK_OUT_ALL-1:0] = blk_out;
    st_d.global_routing_pool[GRP_W-1:BLK_OUT_ALL] = io_in;

    if (reg_req.wr)
    begin
      if (reg_req.addr < OE_CFG_BASE)
      begin
        st_d.io_cfg[reg_req.addr[5:0]] = plc_io_cfg_t'(reg_req.wdata[9:0]);
      end
      else if (reg_req.addr < OE_CFG_BASE + 11'h003)
      begin
        st_d.oe_cfg[reg_req.addr[1:0]] = plc_oe_cfg_t'(reg_req.wdata[6:0]);
      end
      else if (reg_req.addr == CLK_CFG_ADDR)
      begin
        st_d.clk_src = reg_req.wdata[14:0];
      end
      else if ((reg_req.addr >= BLK_CTL_BASE) && (reg_req.addr < BLK_CTL_END))
      begin
        st_d.blk_ctl[5'(reg_req.addr - BLK_CTL_BASE)] = plc_blk_ctl_t'(reg_req.wdata[11:0]);
      end
      else if ((reg_req.addr >= TERM_BASE) && (reg_req.addr < TERM_END))
      begin
        st_d.term[term_off[7:3]][term_off[2:1]][term_off[0]] = reg_req.wdata[BLK_IN-1:0];
      end
      else if ((reg_req.addr >= IN_SEL_BASE) && (reg_req.addr < IN_SEL_END)
               && (sel_off[4:0] <= IN_SEL_LAST))
      begin
        st_d.in_sel[sel_off[9:5]][sel_off[4:0]] = reg_req.wdata[7:0];
      end
    end

    // Unmapped addresses read back as zero.
    st_d.rdata = '0;
    if (reg_req.rd)
    begin
      if (reg_req.addr < OE_CFG_BASE)
      begin
        st_d.rdata = {22'h0, st_q.io_cfg[reg_req.addr[5:0]]};
      end
      else if (reg_req.addr < OE_CFG_BASE + 11'h003)
      begin
        st_d.rdata = {25'h0, st_q.oe_cfg[reg_req.addr[1:0]]};
      end
      else if ((reg_req.addr >= GRP_RD_BASE) && (reg_req.addr < GRP_RD_END))
      begin
        st_d.rdata = grp_pad[grp_off[2:0]*DATA_W +: DATA_W];
      end
      else if (reg_req.addr == CLK_CFG_ADDR)
      begin
        st_d.rdata = {17'h0, st_q.clk_src};
      end
      else if ((reg_req.addr >= BLK_CTL_BASE) && (reg_req.addr < BLK_CTL_END))
      begin
        st_d.rdata = {20'h0, st_q.blk_ctl[5'(reg_req.addr - BLK_CTL_BASE)]};
      end
      else if ((reg_req.addr >= TERM_BASE) && (reg_req.addr < TERM_END))
      begin
        st_d.rdata = {14'h0, st_q.term[term_off[7:3]][term_off[2:1]][term_off[0]]};
      end
      else if ((reg_req.addr >= IN_SEL_BASE) && (reg_req.addr < IN_SEL_END)
               && (sel_off[4:0] <= IN_SEL_LAST))
      begin
        st_d.rdata = {24'h0, st_q.in_sel[sel_off[9:5]][sel_off[4:0]]};
      end
    end
  end

  assign reg_rdata = st_q.rdata;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
    end
  end

endmodule

// >>> rtl/plc_io_cell.sv
// One configurable I/O cell: input capture modes, output polarity and tri-state control.
`timescale 1ns/10ps
module plc_io_cell
  import plc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire plc_io_cfg_t cfg,
  input  wire logic        out_data,
  input  wire logic        cl_oe,
  input  wire logic        line_lvl,
  input  wire logic        line_rise,
  input  wire logic        pin_i,
  output logic             pin_o,
  output logic             pin_oe_b,
  output logic             in_val
);

  typedef struct packed {
    logic reg_q;
    logic latch_q;
  } plc_ioc_state_t;

  plc_ioc_state_t st_q;
  plc_ioc_state_t st_d;
  logic           drives;

  always_comb
  begin
    st_d = st_q;
    if (line_rise)
    begin
      st_d.reg_q = pin_i;
    end
    if (line_lvl)
    begin
      st_d.latch_q = pin_i;
    end
  end

  always_comb
  begin
    unique case (cfg.mode)
      PIO_COMB_IN:  in_val = pin_i;
      PIO_REG_IN:   in_val = st_q.reg_q;
      PIO_LATCH_IN: in_val = line_lvl ? pin_i : st_q.latch_q;
      PIO_BIDIR:    in_val = pin_i;
      default:      in_val = 1'b0;
    endcase
  end

  assign drives   = ((cfg.mode == PIO_OUTPUT) || (cfg.mode == PIO_BIDIR)) && cl_oe;
  assign pin_oe_b = ~drives;
  assign pin_o    = out_data ^ cfg.invert;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
    end
  end

endmodule

// >>> rtl/plc_logic_block_unit.sv
// One logic block unit: product-term array with combinatorial or registered outputs.
`timescale 1ns/10ps
module plc_logic_block_unit
  import plc_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire logic                clk_en,
  input  wire plc_blk_cfg_t        cfg,
  input  wire logic [BLK_IN-1:0]   blk_in,
  input  wire logic [NUM_LCLK-1:0] lclk_rise,
  output logic      [BLK_OUT-1:0]  blk_out
);

  typedef struct packed {
    logic [BLK_OUT-1:0] q;
  } plc_lbu_state_t;

  plc_lbu_state_t     st_q;
  plc_lbu_state_t     st_d;
  logic [BLK_OUT-1:0] term;
  logic [BLK_OUT-1:0] edge_hit;

  for (genvar j = 0; j < BLK_OUT; j++) begin : g_out
    assign term[j] = &((blk_in ^ cfg.inv[j]) | ~cfg.mask[j]);
    // Clock select code 3 is no line at all, so that output register never loads.
    assign edge_hit[j] = (cfg.ctl.clk_sel[j] != 2'h3) && lclk_rise[cfg.ctl.clk_sel[j]];
    assign blk_out[j] = cfg.ctl.reg_en[j] ? st_q.q[j] : term[j];
  end

  always_comb
  begin
    st_d = st_q;
    for (int j = 0; j < BLK_OUT; j++)
    begin
      if (edge_hit[j])
      begin
        st_d.q[j] = term[j];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
    end
  end

endmodule

// >>> rtl/plc_pkg.sv
// Shared constants, types and register map of the programmable logic cluster fabric.
package plc_pkg;

  // Fabric dimensions.
  localparam int NUM_CLUSTERS = 3;
  localparam int BLK_PER_CL   = 8;
  localparam int IO_PER_CL    = 16;
  localparam int NUM_BLK      = 24;
  localparam int NUM_IO       = 48;
  localparam int BLK_IN       = 18;
  localparam int BLK_OUT      = 4;
  localparam int NUM_DED      = 6;
  localparam int NUM_CLK_PIN  = 4;
  localparam int NUM_LCLK     = 3;
  localparam int NUM_IOCLK    = 2;
  localparam int NUM_CLINES   = 5;
  localparam int CL_OUTS      = 32;
  localparam int BLK_OUT_ALL  = 96;
  localparam int GRP_W        = 144;
  localparam int GRP_PAD_W    = 160;
  localparam int CLKGEN_BLK   = 12;

  // Register port widths.
  localparam int ADDR_W = 11;
  localparam int DATA_W = 32;

  // Global routing pool select codes: pool bits first, then dedicated inputs.
  localparam logic [7:0] SEL_GRP_END = 8'h90;
  localparam logic [7:0] SEL_DED_END = 8'h96;

  // Clock line source codes.
  localparam logic [2:0] CSRC_GEN = 3'h4;

  // Register word addresses.
  localparam logic [10:0] IO_CFG_BASE  = 11'h000;
  localparam logic [10:0] OE_CFG_BASE  = 11'h030;
  localparam logic [10:0] GRP_RD_BASE  = 11'h038;
  localparam logic [10:0] GRP_RD_END   = 11'h03d;
  localparam logic [10:0] CLK_CFG_ADDR = 11'h03f;
  localparam logic [10:0] BLK_CTL_BASE = 11'h040;
  localparam logic [10:0] BLK_CTL_END  = 11'h058;
  localparam logic [10:0] TERM_BASE    = 11'h080;
  localparam logic [10:0] TERM_END     = 11'h140;
  localparam logic [10:0] IN_SEL_BASE  = 11'h200;
  localparam logic [10:0] IN_SEL_END   = 11'h500;
  localparam logic [4:0]  IN_SEL_LAST  = 5'h11;

  typedef enum logic [2:0] {
    PIO_COMB_IN  = 3'h0,
    PIO_REG_IN   = 3'h1,
    PIO_LATCH_IN = 3'h2,
    PIO_OUTPUT   = 3'h3,
    PIO_BIDIR    = 3'h4
  } plc_io_mode_t;

  typedef struct packed {
    logic [4:0]   src;
    logic         clk_sel;
    logic         invert;
    plc_io_mode_t mode;
  } plc_io_cfg_t;

  typedef struct packed {
    logic       force_on;
    logic       invert;
    logic [4:0] src;
  } plc_oe_cfg_t;

  typedef struct packed {
    logic [BLK_OUT-1:0][1:0] clk_sel;
    logic [BLK_OUT-1:0]      reg_en;
  } plc_blk_ctl_t;

  typedef struct packed {
    plc_blk_ctl_t                   ctl;
    logic [BLK_OUT-1:0][BLK_IN-1:0] mask;
    logic [BLK_OUT-1:0][BLK_IN-1:0] inv;
  } plc_blk_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } plc_reg_req_t;

  localparam plc_io_cfg_t  IO_CFG_RST  = '0;
  localparam plc_oe_cfg_t  OE_CFG_RST  = '0;
  localparam plc_blk_ctl_t BLK_CTL_RST = '0;

endpackage

// >>> sim/plc_board_model.sv
// Board circuitry on the I/O pins: resolves each pin from both drivers.
`timescale 1ns/10ps
module plc_board_model
  import plc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic [NUM_IO-1:0] io_pin_o,
  input  wire logic [NUM_IO-1:0] io_pin_oe_b,
  input  wire logic [NUM_IO-1:0] ext_val,
  input  wire logic [NUM_IO-1:0] ext_en,
  output logic      [NUM_IO-1:0] io_pin_i
);
  logic [NUM_IO-1:0] wander_q = '0;

  // Pins have no pull, so a line nobody drives wanders instead of keeping a stale level.
  always @(posedge ref_clk)
    wander_q <= ~wander_q;
  assign io_pin_i = (~io_pin_oe_b & io_pin_o) | (io_pin_oe_b & ext_en & ext_val)
                  | (io_pin_oe_b & ~ext_en & wander_q);
endmodule

// >>> sim/plc_cluster_io_asserts.sv
// Port checker for register answers and pin enables of the cluster fabric.
`timescale 1ns/10ps
module plc_cluster_io_asserts
  import plc_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst_b,
  input wire logic              clk_en,
  input wire plc_reg_req_t      reg_req,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [NUM_IO-1:0] io_pin_oe_b
);
  logic [NUM_IO-1:0][2:0]  mode_q;
  logic [NUM_CLUSTERS-1:0] frc_q;
  logic [2:0]              rd_mode_q;
  logic [NUM_IO-1:0]       in_v;
  logic [NUM_IO-1:0]       drv_v;
  logic [NUM_IO-1:0]       frc_v;
  logic                    shared;
  logic                    io_a;

  assign io_a = reg_req.addr < OE_CFG_BASE;
  // Shadow of mode and forced enable, so pin enables can be predicted from the port.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_q    <= '0;
      frc_q     <= '0;
      rd_mode_q <= '0;
    end
    else if (clk_en)
    begin
      if (reg_req.wr && io_a)
        mode_q[reg_req.addr[5:0]] <= reg_req.wdata[2:0];
      if (reg_req.wr && reg_req.addr[10:2] == 9'h00c && reg_req.addr[1:0] != 2'h3)
        frc_q[reg_req.addr[1:0]] <= reg_req.wdata[6];
      if (reg_req.rd && io_a)
        rd_mode_q <= mode_q[reg_req.addr[5:0]];
    end
  end

  always_comb
  begin
    shared = 1'b1;
    for (int p = 0; p < NUM_IO; p++)
    begin
      in_v[p]  = mode_q[p] < 3'h3;
      drv_v[p] = !in_v[p];
      frc_v[p] = frc_q[p / IO_PER_CL];
    end
    for (int c = 0; c < NUM_CLUSTERS; c++)
      shared &= (&(io_pin_oe_b[c*IO_PER_CL +: IO_PER_CL] | ~drv_v[c*IO_PER_CL +: IO_PER_CL]))
        || !(|(io_pin_oe_b[c*IO_PER_CL +: IO_PER_CL] & drv_v[c*IO_PER_CL +: IO_PER_CL]));
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_rd_io;
    clk_en && reg_req.rd && io_a;
  endsequence
  sequence s_rd_gap;
    clk_en && reg_req.rd && reg_req.addr >= IN_SEL_END;
  endsequence

  a_rdata_idle: assert property ($past(clk_en) && !$past(reg_req.rd) |-> reg_rdata == '0)
    else $error("read data present without a read");
  a_rdata_hold: assert property (!clk_en |=> $stable(reg_rdata))
    else $error("read data moved while the clock enable was low");
  a_rst_float: assert property ($rose(rst_b) |-> &io_pin_oe_b)
    else $error("a pin is driven right after reset");
  a_input_hiz: assert property ((~io_pin_oe_b & in_v) == '0)
    else $error("an input cell drives its pin");
  a_forced_drive: assert property ((io_pin_oe_b & drv_v & frc_v) == '0)
    else $error("driver idle under a forced cluster enable");
  a_oe_shared: assert property (shared)
    else $error("driving cells of one cluster disagree on enable");
  a_mode_read: assert property (s_rd_io |=> reg_rdata[2:0] == rd_mode_q)
    else $error("cell mode read back wrong");
  a_gap_zero: assert property (s_rd_gap |=> reg_rdata == '0)
    else $error("unmapped read returned data");
endmodule

// >>> sim/plc_cluster_io_bench.sv
// Self-checking bench for the cluster fabric top.
`timescale 1ns/10ps
module plc_cluster_io_bench
  import plc_pkg::*;
;
  logic               ref_clk;
  logic               rst_b;
  logic               clk_en;
  plc_reg_req_t       req;
  logic [DATA_W-1:0]  rdata;
  logic [NUM_DED-1:0] ded;
  logic [3:0]         cpin;
  logic [NUM_IO-1:0]  pin_i;
  logic [NUM_IO-1:0]  pin_o;
  logic [NUM_IO-1:0]  pin_oe_b;
  logic [NUM_IO-1:0]  ext_val;
  logic [NUM_IO-1:0]  ext_en;
  logic [NUM_IO-1:0]  ev;
  logic [63:0]        exp_q[$];
  logic               rd_seen = 1'b0;
  logic [9:0]         cfg[NUM_IO];
  logic [10:0]        zero_a[9] = '{11'h000, 11'h02f, 11'h030, 11'h03f, 11'h040,
                                    11'h080, 11'h200, 11'h500, 11'h034};
  int                 bad_count;
  int                 total_checks;
  int                 cycles;
  int                 seed;

  plc_cluster_io dut (
    .ref_clk               (ref_clk),
    .rst_b                 (rst_b),
    .clk_en                (clk_en),
    .reg_req               (req),
    .reg_rdata             (rdata),
    .ded_in                (ded),
    .dedicated_clock_pin_0 (cpin[0]),
    .dedicated_clock_pin_1 (cpin[1]),
    .dedicated_clock_pin_2 (cpin[2]),
    .dedicated_clock_pin_3 (cpin[3]),
    .io_pin_i              (pin_i),
    .io_pin_o              (pin_o),
    .io_pin_oe_b           (pin_oe_b)
  );

  plc_board_model board (
    .ref_clk     (ref_clk),
    .io_pin_o    (pin_o),
    .io_pin_oe_b (pin_oe_b),
    .ext_val     (ext_val),
    .ext_en      (ext_en),
    .io_pin_i    (pin_i)
  );

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [10:0] a, input logic [31:0] e, input logic [31:0] m);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    exp_q.push_back({m, e});
    @(posedge ref_clk);
  endtask

  // Drops both strobes and lets n edges pass, so the next stimulus still lands on an edge.
  task automatic idle(input int n);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic check_word(input logic [31:0] got);
    logic [63:0] e;
    e = (exp_q.size() != 0) ? exp_q.pop_front() : '1;
    total_checks++;
    if ((got & e[63:32]) !== (e[31:0] & e[63:32]))
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e[31:0]);
    end
  endtask

  task automatic check_pin(input logic [1:0] got, input logic [1:0] e);
    total_checks++;
    if (got !== e)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    rd_seen <= rst_b && clk_en && req.rd;
    if (rd_seen)
      check_word(rdata);
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      test_done();
    end
  end

  initial
  begin
    rst_b   = 1'b0;
    clk_en  = 1'b1;
    req     = '0;
    cpin    = 4'h0;
    ext_en  = '1;
    seed    = $urandom(32'h0a5868d6);
    ded     = 6'($urandom()) & 6'h3c;
    ev      = {16'($urandom()), $urandom()};
    ext_val = ev;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    idle(1);
    wr(11'h500, 32'hffffffff);
    wr(11'h034, 32'hffffffff);
    foreach (zero_a[i])
      rd(zero_a[i], 32'h0, 32'hffffffff);
    for (int w = 0; w < 3; w++)
      rd(GRP_RD_BASE + 11'(w), 32'hffffffff, 32'hffffffff);
    idle(1);
    clk_en <= 1'b0;
    wr(11'h005, 32'h3);
    clk_en <= 1'b1;
    rd(11'h005, 32'h0, 32'hffffffff);
    wr(OE_CFG_BASE + 11'h2, 32'h40);
    for (int p = 0; p < NUM_IO; p++)
    begin
      cfg[p] = {7'($urandom()), 3'(p % 5)};
      wr(11'(p), {22'h0, cfg[p]});
    end
    for (int p = 0; p < NUM_IO; p++)
      rd(11'(p), {22'h0, cfg[p]}, 32'h3ff);
    for (int p = 0; p < NUM_IO; p++)
      wr(11'(p), 32'h0);
    wr(OE_CFG_BASE + 11'h2, 32'h0);
    idle(3);
    rd(GRP_RD_BASE + 11'h3, ev[31:0], 32'hffffffff);
    rd(GRP_RD_BASE + 11'h4, {16'h0, ev[47:32]}, 32'hffffffff);
    ext_en[0] <= 1'b0;
    wr(OE_CFG_BASE, 32'h40);
    wr(11'h000, 32'h3);
    idle(1);
    // Pin outputs are combinational, so they are looked at mid-cycle, where they have settled.
    @(negedge ref_clk);
    check_pin(pin_oe_b[0], 1'b0);
    check_pin(pin_o[0], 1'b1);
    @(posedge ref_clk);
    wr(11'h000, 32'hb);
    idle(1);
    @(negedge ref_clk);
    check_pin(pin_o[0], 1'b0);
    @(posedge ref_clk);
    wr(11'h010, 32'h4);
    wr(11'h011, 32'h4);
    wr(OE_CFG_BASE + 11'h1, 32'h20);
    idle(3);
    @(negedge ref_clk);
    check_pin(pin_oe_b[17:16], 2'b11);
    @(posedge ref_clk);
    rd(GRP_RD_BASE + 11'h3, {14'h0, ev[17:16], 16'h0}, 32'h30000);
    ext_en[17:16] <= 2'b00;
    wr(OE_CFG_BASE + 11'h1, 32'h0);
    idle(1);
    @(negedge ref_clk);
    check_pin(pin_oe_b[17:16], 2'b00);
    check_pin(pin_o[17:16], 2'b11);
    @(posedge ref_clk);
    wr(11'h000, 32'h0);
    wr(11'h010, 32'h0);
    wr(11'h011, 32'h0);
    ext_en <= '1;
    // Cell 1 registered and cell 2 latched, both on I/O clock line 0 from clock pin 0.
    wr(11'h001, 32'h1);
    wr(11'h002, 32'h2);
    ev[2:1] = 2'b11;
    ext_val <= ev;
    idle(2);
    cpin[0] <= 1'b1;
    idle(1);
    cpin[0] <= 1'b0;
    idle(1);
    ev[2:1] = 2'b00;
    ext_val <= ev;
    idle(3);
    rd(GRP_RD_BASE + 11'h3, 32'h6, 32'h6);
    cpin[0] <= 1'b1;
    idle(2);
    ev[2:1] = 2'b11;
    ext_val <= ev;
    idle(3);
    rd(GRP_RD_BASE + 11'h3, 32'h4, 32'h6);
    cpin[0] <= 1'b0;
    // Block 12 output 0 follows dedicated input 0 and clocks logic line 0 of block 3.
    wr(IN_SEL_BASE + 11'h180, 32'h90);
    wr(TERM_BASE + 11'h60, 32'h1);
    wr(IN_SEL_BASE + 11'h060, 32'h91);
    wr(TERM_BASE + 11'h18, 32'h1);
    wr(BLK_CTL_BASE + 11'h3, 32'h1);
    wr(CLK_CFG_ADDR, 32'h4);
    for (int k = 0; k < 2; k++)
    begin
      ded[1] <= 1'(1 - k);
      idle(3);
      ded[0] <= 1'b1;
      idle(3);
      rd(GRP_RD_BASE + 11'h1, 32'h10000, 32'h10000);
      ded[1] <= 1'(k);
      ded[0] <= 1'b0;
      idle(3);
      rd(GRP_RD_BASE, {19'h0, 1'(1 - k), 12'h0}, 32'h1000);
    end
    // Block 5 output 0 reads pool bit 48; cell 3 samples on I/O line 1 fed by clock pin 3.
    wr(IN_SEL_BASE + 11'h0a0, 32'h30);
    wr(TERM_BASE + 11'h28, 32'h1);
    wr(11'h003, 32'h11);
    wr(CLK_CFG_ADDR, 32'h3004);
    ev[3] = 1'b1;
    ext_val <= ev;
    ded[0] <= 1'b1;
    idle(3);
    cpin[3] <= 1'b1;
    idle(1);
    cpin[3] <= 1'b0;
    ev[3] = 1'b0;
    ext_val <= ev;
    idle(3);
    rd(GRP_RD_BASE, 32'h100000, 32'h100000);
    rd(GRP_RD_BASE + 11'h3, 32'h8, 32'h8);
    ded[0] <= 1'b0;
    idle(3);
    rd(GRP_RD_BASE, 32'h0, 32'h100000);
    rd(GRP_RD_BASE + 11'h3, 32'h8, 32'h8);
    idle(3);
    test_done();
  end
endmodule

bind plc_cluster_io plc_cluster_io_asserts u_chk (
  .ref_clk     (ref_clk),
  .rst_b       (rst_b),
  .clk_en      (clk_en),
  .reg_req     (reg_req),
  .reg_rdata   (reg_rdata),
  .io_pin_oe_b (io_pin_oe_b)
);
